// [io_space_pkg.sv]
package io_space_pkg;
   localparam logic [12:0] single_cycle_last = 13'h003f;
   localparam logic [12:0] bit_access_last = 13'h001f;
   localparam logic [12:0] ext_first = 13'h0040;
   localparam logic [12:0] ext_last = 13'h103f;
   localparam logic [12:0] gp_byte_base = 13'h001c;
   localparam int gp_byte_count = 4;
   localparam logic [7:0] gp_byte_reset = 8'h00;
   localparam logic [7:0] staging_reset = 8'h00;
   // Demo wide peripheral: 16-bit at +0/+1, 24-bit at +2..+4
   localparam logic [12:0] wide_base = 13'h0f00;
   localparam logic [12:0] wide16_lo = 13'h0f00;
   localparam logic [12:0] wide16_hi = 13'h0f01;
   localparam logic [12:0] wide24_b0 = 13'h0f02;
   localparam logic [12:0] wide24_b1 = 13'h0f03;
   localparam logic [12:0] wide24_b2 = 13'h0f04;
   localparam logic [15:0] wide16_reset = 16'h0000;
   localparam logic [23:0] wide24_reset = 24'h00_0000;
   typedef enum logic [2:0] {
      op_in = 3'b000,
      op_out = 3'b001,
      op_set_bit = 3'b010,
      op_clear_bit = 3'b011,
      op_load = 3'b100,
      op_store = 3'b101,
      op_test_bit = 3'b110
   } io_op_t;
endpackage

// [wide_staging.sv]
`timescale 1ns/10ps
module wide_staging (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Decoded byte access
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [12:0] addr,
   input wire logic [7:0] wdata,
   // Read data
   output logic [7:0] rdata,
   output logic hit,
   // Live register values
   output logic [15:0] value16,
   output logic [23:0] value24
);
   logic [15:0] v16_reg, v16_next;
   logic [23:0] v24_reg, v24_next;
   // Two staging bytes: stg0 shared by both wide registers, stg1 used by the 24-bit one only
   logic [7:0] stg0_reg, stg0_next, stg1_reg, stg1_next;

   always_comb begin
      v16_next = v16_reg;
      v24_next = v24_reg;
      stg0_next = stg0_reg;
      stg1_next = stg1_reg;
      rdata = 8'h00;
      hit = 1'b1;
      unique case (addr)
         io_space_pkg::wide16_lo: begin
            rdata = v16_reg[7:0];
            if (wr_en) stg0_next = wdata;
            if (rd_en) stg0_next = v16_reg[15:8];
         end
         io_space_pkg::wide16_hi: begin
            rdata = stg0_reg;
            if (wr_en) v16_next = {wdata, stg0_reg};
         end
         io_space_pkg::wide24_b0: begin
            rdata = v24_reg[7:0];
            if (wr_en) stg0_next = wdata;
            if (rd_en) begin
               stg0_next = v24_reg[15:8];
               stg1_next = v24_reg[23:16];
            end
         end
         io_space_pkg::wide24_b1: begin
            rdata = stg0_reg;
            if (wr_en) stg1_next = wdata;
         end
         io_space_pkg::wide24_b2: begin
            rdata = stg1_reg;
            if (wr_en) v24_next = {wdata, stg1_reg, stg0_reg};
         end
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         v16_reg <= io_space_pkg::wide16_reset;
         v24_reg <= io_space_pkg::wide24_reset;
         stg0_reg <= io_space_pkg::staging_reset;
         stg1_reg <= io_space_pkg::staging_reset;
      end else begin
         v16_reg <= v16_next;
         v24_reg <= v24_next;
         stg0_reg <= stg0_next;
         stg1_reg <= stg1_next;
      end
   end

   assign value16 = v16_reg;
   assign value24 = v24_reg;
endmodule

// [io_space_register_access.sv]
`timescale 1ns/10ps
module io_space_register_access (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // CPU access, one per cycle while req is high
   input wire logic req,
   input wire logic [2:0] op,
   input wire logic [12:0] addr,
   input wire logic [2:0] bit_sel,
   input wire logic [7:0] wdata,
   // Answer, one cycle after the request
   output logic [7:0] rdata,
   output logic ack,
   output logic skip,
   // Wide register values for the peripheral core
   output logic [15:0] wide16_value,
   output logic [23:0] wide24_value
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   // General purpose bytes
   logic [7:0] gp_reg [io_space_pkg::gp_byte_count];
   logic [7:0] gp_next [io_space_pkg::gp_byte_count];
   logic [io_space_pkg::gp_byte_count-1:0] gp_sel;
   logic [7:0] gp_rd [io_space_pkg::gp_byte_count];
   // Answer registers
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic ack_reg;
   logic ack_next;
   logic skip_reg;
   logic skip_next;
   // Mirrors of the wide values for the peripheral core
   logic [15:0] w16_reg;
   logic [15:0] w16_next;
   logic [23:0] w24_reg;
   logic [23:0] w24_next;
   // Address classes
   logic is_single;
   logic is_bitreg;
   logic is_ext;
   // Opcode classes
   logic is_port_op;
   logic is_ldst_op;
   logic is_bitop;
   logic is_write_op;
   logic is_read_op;
   // Qualified access
   logic op_ok;
   logic is_wr;
   logic is_rd;
   // Read path
   logic [7:0] gp_cur;
   logic [7:0] cur;
   logic [7:0] mask;
   // Wide peripheral
   logic st_wr;
   logic st_rd;
   logic st_hit;
   logic [7:0] st_rdata;
   logic [15:0] v16;
   logic [23:0] v24;

   // ----------------------------------------------------------------
   // Address classes
   // ----------------------------------------------------------------
   assign is_single = addr <= io_space_pkg::single_cycle_last;
   assign is_bitreg = addr <= io_space_pkg::bit_access_last;
   assign is_ext = addr >= io_space_pkg::ext_first &&
      addr <= io_space_pkg::ext_last;

   // ----------------------------------------------------------------
   // Opcode classes
   // ----------------------------------------------------------------
   assign is_port_op = op == io_space_pkg::op_in ||
      op == io_space_pkg::op_out;
   assign is_ldst_op = op == io_space_pkg::op_load ||
      op == io_space_pkg::op_store;
   assign is_bitop = op == io_space_pkg::op_set_bit ||
      op == io_space_pkg::op_clear_bit || op == io_space_pkg::op_test_bit;
   assign is_write_op = op == io_space_pkg::op_out ||
      op == io_space_pkg::op_store || op == io_space_pkg::op_set_bit ||
      op == io_space_pkg::op_clear_bit;
   assign is_read_op = op == io_space_pkg::op_in ||
      op == io_space_pkg::op_load || op == io_space_pkg::op_test_bit;

   // ----------------------------------------------------------------
   // Access qualification
   // ----------------------------------------------------------------
   // Port-style ops only below 0x40, load/store anywhere mapped
   always_comb begin
      op_ok = 1'b0;
      if (is_bitop) begin
         op_ok = is_bitreg;
      end else if (is_port_op) begin
         op_ok = is_single;
      end else if (is_ldst_op) begin
         op_ok = is_single || is_ext;
      end
   end
   // A refused access still acks, but touches no state
   assign is_wr = req && op_ok && is_write_op;
   assign is_rd = req && op_ok && is_read_op;
   assign mask = 8'h01 << bit_sel;

   // ----------------------------------------------------------------
   // Wide peripheral with its own staging bytes
   // ----------------------------------------------------------------
   assign st_wr = is_wr && is_ext;
   assign st_rd = is_rd && is_ext;
   wide_staging u_stage (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(st_wr),
      .rd_en(st_rd),
      .addr(addr),
      .wdata(wdata),
      .rdata(st_rdata),
      .hit(st_hit),
      .value16(v16),
      .value24(v24)
   );

   // ----------------------------------------------------------------
   // General purpose bytes, one storage group per entry
   // ----------------------------------------------------------------
   // Plain storage: these bits feed only the read data and skip paths
   for (genvar g = 0; g < io_space_pkg::gp_byte_count; g++) begin : g_gp
      assign gp_sel[g] = addr == io_space_pkg::gp_byte_base + 13'(g);
      assign gp_rd[g] = gp_sel[g] ? gp_reg[g] : 8'h00;

      always_comb begin
         gp_next[g] = gp_reg[g];
         if (is_wr && gp_sel[g]) begin
            unique case (op)
               io_space_pkg::op_set_bit: gp_next[g] = gp_reg[g] | mask;
               io_space_pkg::op_clear_bit: gp_next[g] = gp_reg[g] & ~mask;
               default: gp_next[g] = wdata;
            endcase
         end
      end

      always_ff @(posedge ref_clk) begin
         if (!rst_n) begin
            gp_reg[g] <= io_space_pkg::gp_byte_reset;
         end else begin
            gp_reg[g] <= gp_next[g];
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data selection
   // ----------------------------------------------------------------
   // Unmapped addresses fall through to zero
   always_comb begin
      gp_cur = 8'h00;
      for (int i = 0; i < io_space_pkg::gp_byte_count; i++) begin
         gp_cur = gp_cur | gp_rd[i];
      end
   end

   always_comb begin
      cur = 8'h00;
      if (is_single) begin
         cur = gp_cur;
      end else if (is_ext && st_hit) begin
         cur = st_rdata;
      end
   end

   // ----------------------------------------------------------------
   // Answer registers
   // ----------------------------------------------------------------
   // Ack on every request, refused or not, so the master never stalls
   always_comb begin
      ack_next = req;
      rdata_next = 8'h00;
      skip_next = 1'b0;
      if (is_rd) begin
         if (op == io_space_pkg::op_test_bit) begin
            skip_next = |(cur & mask);
         end else begin
            rdata_next = cur;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_reg <= 8'h00;
         ack_reg <= 1'b0;
         skip_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
         skip_reg <= skip_next;
      end
   end

   // ----------------------------------------------------------------
   // Wide value mirrors
   // ----------------------------------------------------------------
   // One cycle of lag buys outputs straight from flip-flops
   always_comb begin
      w16_next = v16;
      w24_next = v24;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         w16_reg <= io_space_pkg::wide16_reset;
         w24_reg <= io_space_pkg::wide24_reset;
      end else begin
         w16_reg <= w16_next;
         w24_reg <= w24_next;
      end
   end

   assign rdata = rdata_reg;
   assign ack = ack_reg;
   assign skip = skip_reg;
   assign wide16_value = w16_reg;
   assign wide24_value = w24_reg;
endmodule

// [io_space_register_access_sva.sv]
`timescale 1ns/10ps
module io_space_register_access_sva (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Request
   input wire logic req,
   input wire logic [2:0] op,
   input wire logic [12:0] addr,
   // Answer
   input wire logic [7:0] rdata,
   input wire logic ack,
   input wire logic skip,
   input wire logic [15:0] wide16_value,
   input wire logic [23:0] wide24_value
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   wire logic hi16 = req && op == io_space_pkg::op_store
      && addr == io_space_pkg::wide16_hi;
   wire logic hi24 = req && op == io_space_pkg::op_store
      && addr == io_space_pkg::wide24_b2;
   sequence taken(o, lo, hi);
      req && op == o && addr >= lo && addr <= hi;
   endsequence
   ack_follows_req_a: assert property (req |=> ack)
      else $error("ack missing after request");
   ack_needs_req_a: assert property (ack |-> $past(req))
      else $error("ack without request");
   write_reads_zero_a: assert property (
      taken(io_space_pkg::op_store, 0, 13'h1fff) |=> rdata == 8'h00)
      else $error("store returned data");
   port_range_a: assert property (
      taken(io_space_pkg::op_in, 13'h0040, 13'h1fff) |=> rdata == 8'h00)
      else $error("port read beyond range");
   ext_range_a: assert property (
      taken(io_space_pkg::op_load, 13'h1040, 13'h1fff) |=> rdata == 8'h00)
      else $error("load beyond extended range");
   skip_cause_a: assert property (skip |-> $past(req && addr <=
      13'h001f && op == io_space_pkg::op_test_bit))
      else $error("skip without bit test");
   wide16_commit_a: assert property ($changed(wide16_value)
      |-> $past(hi16) || $past(hi16, 2))
      else $error("wide16 changed without high write");
   wide24_commit_a: assert property ($changed(wide24_value)
      |-> $past(hi24) || $past(hi24, 2))
      else $error("wide24 changed without top write");
endmodule

// [cpu_bus_model.sv]
`timescale 1ns/10ps
module cpu_bus_model (
   // Clock
   input wire logic ref_clk,
   // Request
   output logic req,
   output logic [2:0] op,
   output logic [12:0] addr,
   output logic [2:0] bit_sel,
   output logic [7:0] wdata,
   // Answer
   input wire logic [7:0] rdata,
   input wire logic ack,
   input wire logic skip
);
   logic [7:0] rd;
   logic sk;
   logic ak;
   initial begin
      req = 1'b0;
      op = 3'h0;
      addr = 13'h0000;
      bit_sel = 3'h0;
      wdata = 8'h00;
   end
   // Request lasts one cycle; a held req would count twice
   task automatic acc(input logic [2:0] o, input logic [12:0] a,
         input logic [2:0] b, input logic [7:0] d);
      @(negedge ref_clk);
      // One access at a time, so nothing cuts into a wide pair
      req = 1'b1;
      op = o;
      addr = a;
      bit_sel = b;
      wdata = d;
      // Answer stands one cycle only: take it before the next edge
      @(negedge ref_clk);
      rd = rdata;
      sk = skip;
      ak = ack;
      req = 1'b0;
      wdata = ~d;
      // Spare cycle lets the registered wide mirrors settle
      @(negedge ref_clk);
   endtask
endmodule

// [io_space_register_access_tb_top.sv]
`timescale 1ns/10ps
module io_space_register_access_tb_top;
   localparam logic [2:0] o_in = io_space_pkg::op_in;
   localparam logic [2:0] o_out = io_space_pkg::op_out;
   localparam logic [2:0] o_ld = io_space_pkg::op_load;
   localparam logic [2:0] o_st = io_space_pkg::op_store;
   logic ref_clk;
   logic rst_n;
   logic req;
   logic [2:0] op;
   logic [12:0] addr;
   logic [2:0] bit_sel;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic ack;
   logic skip;
   logic [15:0] w16;
   logic [23:0] w24;
   int errors;
   int comparisons;
   io_space_register_access dut (.ref_clk(ref_clk), .rst_n(rst_n),
      .req(req), .op(op), .addr(addr), .bit_sel(bit_sel), .wdata(wdata),
      .rdata(rdata), .ack(ack), .skip(skip), .wide16_value(w16),
      .wide24_value(w24));
   cpu_bus_model cpu (.ref_clk(ref_clk), .req(req), .op(op), .addr(addr),
      .bit_sel(bit_sel), .wdata(wdata), .rdata(rdata), .ack(ack),
      .skip(skip));
   task chk(input string n, input logic [23:0] s, input logic [23:0] e);
      comparisons++;
      if (s !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task t(input logic [2:0] o, input logic [12:0] a, input logic [2:0] b,
         input logic [7:0] d, input logic [7:0] e);
      cpu.acc(o, a, b, d);
      chk("rdata", {16'h0000, cpu.rd}, {16'h0000, e});
      chk("ack", {23'h0, cpu.ak}, 24'h00_0001);
   endtask
   task report_and_stop;
      if (errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // Whole sequence needs about 100 cycles
   initial begin
      #20000;
      errors++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0;
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      for (int i = 0; i < 4; i++) begin
         t(o_ld, 13'h001c + 13'(i), 3'h0, 8'h00, 8'h00);
         t(o_out, 13'h001c + 13'(i), 3'h0, 8'h5a ^ 8'(i), 8'h00);
         t(o_in, 13'h001c + 13'(i), 3'h0, 8'h00, 8'h5a ^ 8'(i));
      end
      t(io_space_pkg::op_set_bit, 13'h001d, 3'h7, 8'h00, 8'h00);
      t(io_space_pkg::op_clear_bit, 13'h001d, 3'h0, 8'h00, 8'h00);
      t(o_in, 13'h001d, 3'h0, 8'h00, 8'hda);
      for (int i = 0; i < 2; i++) begin
         t(io_space_pkg::op_test_bit, 13'h001d, 3'(7 * i), 8'h00, 8'h00);
         chk("skip", {23'h0, cpu.sk}, 24'(i));
      end
      t(o_st, 13'h0f00, 3'h0, 8'h34, 8'h00);
      chk("wide16", {8'h00, w16}, 24'h00_0000);
      t(o_st, 13'h0f01, 3'h0, 8'h12, 8'h00);
      t(o_out, 13'h0f01, 3'h0, 8'hee, 8'h00);
      chk("wide16", {8'h00, w16}, 24'h00_1234);
      t(o_in, 13'h0f00, 3'h0, 8'h00, 8'h00);
      t(o_ld, 13'h0f00, 3'h0, 8'h00, 8'h34);
      t(o_ld, 13'h0f01, 3'h0, 8'h00, 8'h12);
      t(o_st, 13'h0f02, 3'h0, 8'hcc, 8'h00);
      t(o_st, 13'h0f03, 3'h0, 8'hbb, 8'h00);
      chk("wide24", w24, 24'h00_0000);
      t(o_st, 13'h0f04, 3'h0, 8'haa, 8'h00);
      chk("wide24", w24, 24'haa_bbcc);
      for (int i = 0; i < 3; i++) begin
         t(o_ld, 13'h0f02 + 13'(i), 3'h0, 8'h00, 8'hcc - 8'(17 * i));
      end
      t(o_ld, 13'h1100, 3'h0, 8'h00, 8'h00);
      t(o_ld, 13'h0500, 3'h0, 8'h00, 8'h00);
      report_and_stop();
   end
endmodule
bind io_space_register_access io_space_register_access_sva u_sva (
   .ref_clk(ref_clk), .rst_n(rst_n), .req(req), .op(op), .addr(addr),
   .rdata(rdata), .ack(ack), .skip(skip), .wide16_value(wide16_value),
   .wide24_value(wide24_value));
